// ---- rtl/afe_control_register_bank.v ----
// Control register bank with master clock divider and AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "afe_control_defs.vh"

module afe_control_register_bank #(
  parameter CHANNELS = 6
) (
  input wire mclk,
  input wire reset_n,
  input wire clockEnable,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire programMode,
  output wire dataMode,
  output wire mixedMode,
  output wire serialLoopbackEnable,
  output wire [2:0] cascadeCount,
  output wire controlEchoEnable,
  output wire dividedMasterClock,
  output wire serialClockTick,
  output wire sampleTick,
  output wire softResetActive,
  output wire [CHANNELS-1:0] channelPowerOn,
  output wire [3*CHANNELS-1:0] channelGainCode,
  output wire referencePowerOn,
  output wire referencePinOutputEnable,
  output wire highSupplyModeEnable,
  output wire [CHANNELS-1:0] modulatorReset,
  output wire [CHANNELS-1:0] singleEndedInput,
  output wire [CHANNELS-1:0] polarityFlip,
  output wire testModeBit
);

  // ==========================================
  // Register storage
  reg [7:0] ctrl [0:7];
  reg [7:0] next_ctrl0;
  reg softReset;
  reg [2:0] softResetCount;
  reg addrPhase;
  reg addrWrite;
  reg [3:0] addrIndex;
  reg [2:0] masterCount;
  reg [2:0] serialCount;
  reg [10:0] sampleCount;
  reg [2:0] masterRatio;
  reg [2:0] serialMask;
  reg [10:0] sampleMask;
  wire busWrite;
  wire [2:0] writeIndex;
  wire anyChannel;
  wire [7:0] storeData;
  wire forwardHit;
  wire [7:0] statusByte;
  integer i;

  // ==========================================
  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busWrite = addrPhase && addrWrite && (addrIndex[3] == 1'b0);
  assign writeIndex = addrIndex[2:0];

  // Address phase capture
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addrPhase <= 1'b0;
      addrWrite <= 1'b0;
      addrIndex <= 4'h0;
    end else if (clockEnable && hready) begin
      addrPhase <= hsel && htrans[1];
      addrWrite <= hwrite;
      addrIndex <= haddr[5:2];
    end
  end

  // Mode register next value: the reset bit clears itself
  always @* begin
    next_ctrl0 = hwdata[7:0];
    next_ctrl0[`SOFT_RESET_BIT] = 1'b0;
  end

  // Register writes, hardware and software reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        ctrl[i] <= `CTRL_RESET_VALUE;
      end
    end else if (clockEnable) begin
      if (softReset) begin
        for (i = 0; i < 8; i = i + 1) begin
          ctrl[i] <= `CTRL_RESET_VALUE;
        end
      end else if (busWrite) begin
        if (writeIndex == `IDX_MODE_CASCADE_CONTROL) begin
          ctrl[0] <= next_ctrl0;
        end else begin
          ctrl[writeIndex] <= hwdata[7:0];
        end
      end
    end
  end

  // Software reset lasts four divided clock cycles
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      softReset <= 1'b0;
      softResetCount <= 3'h0;
    end else if (clockEnable) begin
      if (!softReset && busWrite && writeIndex == `IDX_MODE_CASCADE_CONTROL &&
          hwdata[`SOFT_RESET_BIT]) begin
        softReset <= 1'b1;
        softResetCount <= 3'h0;
      end else if (softReset && dividedMasterClock) begin
        if (softResetCount == `SOFT_RESET_DIV_CYCLES - 3'h1) begin
          softReset <= 1'b0;
        end
        softResetCount <= softResetCount + 3'h1;
      end
    end
  end
  assign softResetActive = softReset;

  // Byte a completing write stores; a read of the same register sees it at once
  assign storeData = (writeIndex == `IDX_MODE_CASCADE_CONTROL) ? next_ctrl0 : hwdata[7:0];
  assign forwardHit = busWrite && !softReset && (writeIndex == haddr[4:2]);
  // Status byte: soft reset, reference, three modes, master ratio
  assign statusByte = {softReset, referencePowerOn, mixedMode, dataMode, programMode, masterRatio};

  // Read data, low byte only; status word at index 8
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (clockEnable && hready) begin
      if (hsel && htrans[1] && !hwrite) begin
        if (haddr[5] == 1'b0) begin
          hrdata <= {24'h000000, forwardHit ? storeData : ctrl[haddr[4:2]]};
        end else if (haddr[5:2] == `IDX_STATUS) begin
          hrdata <= {24'h000000, statusByte};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // ==========================================
  // Operating mode decode
  assign mixedMode = ctrl[0][`MIXED_MODE_BIT];
  assign programMode = !ctrl[0][`MIXED_MODE_BIT] && !ctrl[0][`OPERATING_MODE_BIT];
  assign dataMode = !ctrl[0][`MIXED_MODE_BIT] && ctrl[0][`OPERATING_MODE_BIT];
  assign serialLoopbackEnable = ctrl[0][`LOOPBACK_BIT];
  assign cascadeCount = ctrl[0][`CASCADE_MSB:`CASCADE_LSB];
  assign controlEchoEnable = ctrl[1][`ECHO_BIT];

  // ==========================================
  // Divider code decode
  always @* begin
    case (ctrl[1][`MASTER_DIV_MSB:`MASTER_DIV_LSB])
      3'h1: masterRatio = 3'h1;
      3'h2: masterRatio = 3'h2;
      3'h3: masterRatio = 3'h3;
      3'h4: masterRatio = 3'h4;
      default: masterRatio = 3'h0;
    endcase
    case (ctrl[1][`SERIAL_DIV_MSB:`SERIAL_DIV_LSB])
      2'h0: serialMask = 3'h7;
      2'h1: serialMask = 3'h3;
      2'h2: serialMask = 3'h1;
      default: serialMask = 3'h0;
    endcase
    case (ctrl[1][`DECIMATION_MSB:`DECIMATION_LSB])
      2'h0: sampleMask = `SAMPLE_DIV_MAX;
      2'h1: sampleMask = 11'h3ff;
      2'h2: sampleMask = 11'h1ff;
      default: sampleMask = 11'h0ff;
    endcase
  end

  // Master divider counter produces the divided clock pulse
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      masterCount <= 3'h0;
    end else if (clockEnable) begin
      if (masterCount >= masterRatio) begin
        masterCount <= 3'h0;
      end else begin
        masterCount <= masterCount + 3'h1;
      end
    end
  end
  assign dividedMasterClock = clockEnable && (masterCount >= masterRatio);

  // Serial and sample counters advance on divided clock only
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      serialCount <= 3'h0;
      sampleCount <= 11'h000;
    end else if (dividedMasterClock) begin
      serialCount <= (serialCount >= serialMask) ? 3'h0 : serialCount + 3'h1;
      sampleCount <= (sampleCount >= sampleMask) ? 11'h000 : sampleCount + 11'h001;
    end
  end
  assign serialClockTick = dividedMasterClock && (serialCount >= serialMask);
  assign sampleTick = dividedMasterClock && (sampleCount >= sampleMask);

  // ==========================================
  // Per-channel power, gain, modulator, input and polarity
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : channelMap
      wire [3:0] nibble = (ch % 2 == 1) ? ctrl[3 + ch / 2][7:4] : ctrl[3 + ch / 2][3:0];
      assign channelGainCode[3*ch+2:3*ch] = nibble[`GAIN_MSB:`GAIN_LSB];
      assign channelPowerOn[ch] = nibble[`CHANNEL_POWER_BIT] || ctrl[2][`GLOBAL_POWER_BIT];
      assign modulatorReset[ch] = ctrl[6][`MOD_RESET_BIT] && ctrl[6][`SELECT_LSB + ch];
      assign singleEndedInput[ch] = ctrl[6][`SINGLE_ENDED_BIT] && ctrl[6][`SELECT_LSB + ch];
      assign polarityFlip[ch] = ctrl[7][`INVERT_BIT] && ctrl[7][`SELECT_LSB + ch];
    end
  endgenerate

  // Reference and supply controls
  assign anyChannel = |channelPowerOn;
  assign referencePowerOn = ctrl[2][`REF_POWER_BIT] || anyChannel;
  assign referencePinOutputEnable = ctrl[2][`REF_PIN_BIT];
  assign highSupplyModeEnable = ctrl[2][`HIGH_SUPPLY_BIT];
  assign testModeBit = ctrl[7][`TEST_MODE_BIT];

endmodule // afe_control_register_bank
`default_nettype wire

// ---- common/afe_control_defs.vh ----
// Register offsets, field positions, reset values and timing counts of the control register bank
`ifndef AFE_CONTROL_DEFS_VH
`define AFE_CONTROL_DEFS_VH

// ==========================================
// Register indices (byte address = 4 * index)
`define IDX_MODE_CASCADE_CONTROL 3'h0
`define IDX_CLOCK_RATE_CONTROL 3'h1
`define IDX_POWER_REFERENCE_CONTROL 3'h2
`define IDX_CHANNEL12_GAIN_POWER 3'h3
`define IDX_CHANNEL34_GAIN_POWER 3'h4
`define IDX_CHANNEL56_GAIN_POWER 3'h5
`define IDX_MODULATOR_INPUT_CONFIG 3'h6
`define IDX_CHANNEL_POLARITY_TEST 3'h7
`define IDX_STATUS 4'h8

// ==========================================
// Reset value of every control register
`define CTRL_RESET_VALUE 8'h00

// ==========================================
// Mode register fields
`define OPERATING_MODE_BIT 0
`define MIXED_MODE_BIT 1
`define MODE_RESERVED_BIT 2
`define LOOPBACK_BIT 3
`define CASCADE_LSB 4
`define CASCADE_MSB 6
`define SOFT_RESET_BIT 7

// Clock register fields
`define DECIMATION_LSB 0
`define DECIMATION_MSB 1
`define SERIAL_DIV_LSB 2
`define SERIAL_DIV_MSB 3
`define MASTER_DIV_LSB 4
`define MASTER_DIV_MSB 6
`define ECHO_BIT 7

// Power register fields
`define GLOBAL_POWER_BIT 0
`define REF_POWER_BIT 5
`define REF_PIN_BIT 6
`define HIGH_SUPPLY_BIT 7

// Channel register nibble layout
`define GAIN_LSB 0
`define GAIN_MSB 2
`define CHANNEL_POWER_BIT 3

// Config and polarity register fields
`define SELECT_LSB 0
`define SELECT_MSB 5
`define MOD_RESET_BIT 6
`define SINGLE_ENDED_BIT 7
`define TEST_MODE_BIT 6
`define INVERT_BIT 7

// ==========================================
// Timing counts
`define SOFT_RESET_DIV_CYCLES 3'h4
`define SAMPLE_DIV_MAX 11'h7ff

`endif

// ---- bench/afe_control_register_bank_props.sv ----
// Checker of mode decode, soft reset and divided clock relations
`timescale 1ns/1ns
`default_nettype none
module afe_control_register_bank_props #(
  parameter CHANNELS = 6
) (
  input wire mclk,
  input wire reset_n,
  input wire clockEnable,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire programMode,
  input wire dataMode,
  input wire mixedMode,
  input wire dividedMasterClock,
  input wire serialClockTick,
  input wire sampleTick,
  input wire softResetActive,
  input wire [CHANNELS-1:0] channelPowerOn,
  input wire referencePowerOn,
  input wire [CHANNELS-1:0] polarityFlip
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Mode register write, address then data phase
  sequence s_addr;
    hsel && hready && htrans[1] && hwrite && clockEnable && haddr == 32'h0 && !softResetActive;
  endsequence
  sequence s_data;
    s_addr ##1 clockEnable && hready;
  endsequence
  property p_modeDecode;
    s_data ##0 !hwdata[7] |=> dataMode == ($past(hwdata[1:0]) == 2'b01) && mixedMode == $past(hwdata[1]);
  endproperty
  a_modeDecode: assert property (p_modeDecode) else $error("mode decode");
  property p_softStart;
    s_data ##0 hwdata[7] |-> ##[1:2] softResetActive;
  endproperty
  a_softStart: assert property (p_softStart) else $error("no soft reset");
  property p_softEnd;
    softResetActive |-> ##[1:12] !softResetActive;
  endproperty
  a_softEnd: assert property (p_softEnd) else $error("soft reset stuck");
  property p_softClear;
    softResetActive && $past(softResetActive) |-> programMode && channelPowerOn == '0 && polarityFlip == '0;
  endproperty
  a_softClear: assert property (p_softClear) else $error("regs not cleared");
  property p_progExcl;
    programMode |-> !dataMode && !mixedMode;
  endproperty
  a_progExcl: assert property (p_progExcl) else $error("program mode overlap");
  property p_mixedExcl;
    mixedMode |-> !programMode && !dataMode;
  endproperty
  a_mixedExcl: assert property (p_mixedExcl) else $error("mixed mode overlap");
  property p_refAuto;
    |channelPowerOn |-> referencePowerOn;
  endproperty
  a_refAuto: assert property (p_refAuto) else $error("reference off");
  property p_tickBase;
    sampleTick || serialClockTick |-> dividedMasterClock;
  endproperty
  a_tickBase: assert property (p_tickBase) else $error("tick off base");
  property p_freeze;
    !clockEnable |=> $stable({programMode, dataMode, mixedMode, channelPowerOn, polarityFlip, softResetActive});
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // afe_control_register_bank_props
`default_nettype wire

// ---- bench/afe_dsp_partner.sv ----
// Bus master standing in for the controller
`timescale 1ns/1ns
`default_nettype none
module afe_dsp_partner (
  input wire mclk,
  input wire hreadyout,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int timeouts = 0;
  // Idle bus at time zero
  initial begin
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
  end
  // Bounded wait for ready
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) timeouts++;
  endtask
  // One single word transfer
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    waitReady();
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    waitReady();
    q = hrdata;
    hwdata <= ~d; // Released data not left standing
  endtask
endmodule // afe_dsp_partner
`default_nettype wire

// ---- bench/afe_control_register_bank_tb.sv ----
// Self-checking bench of the control register bank
`timescale 1ns/1ns
`default_nettype none
module afe_control_register_bank_tb;
  logic mclk, reset_n, clockEnable;
  wire hsel, hwrite, hready, hreadyout, hresp, programMode, dataMode, mixedMode, serialLoopbackEnable;
  wire controlEchoEnable, dividedMasterClock, serialClockTick, sampleTick, softResetActive, referencePowerOn;
  wire referencePinOutputEnable, highSupplyModeEnable, testModeBit;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize, cascadeCount;
  wire [5:0] channelPowerOn, modulatorReset, singleEndedInput, polarityFlip;
  wire [17:0] channelGainCode;
  int failures, comparisons, i;
  logic [31:0] rd, n;
  logic [7:0] pat [8] = '{8'h50, 8'h9b, 8'he1, 8'hd5, 8'h3a, 8'hb6, 8'hc5, 8'h8a};
  assign hready = hreadyout;
  afe_control_register_bank uut (.*);
  afe_dsp_partner dsp (.*);
  // Compare and count
  task automatic check(input logic [31:0] single_ended_enable, input logic [31:0] exp);
    comparisons++;
    if (single_ended_enable !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: single_ended_enable %h expected %h", $time, single_ended_enable, exp);
    end
  endtask
  task automatic conclude;
    failures += dsp.timeouts;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    dsp.xfer(1'b1, a, d, rd);
    if (dsp.timeouts != 0) conclude();
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    dsp.xfer(1'b0, a, 32'h0, rd);
    if (dsp.timeouts != 0) conclude();
    check(rd, e);
  endtask
  // Cycles between two pulses of one tick output
  task automatic period(input int s, output logic [31:0] c);
    int k, single_ended_enable;
    single_ended_enable = 0;
    c = 0;
    for (k = 0; k < 5000 && single_ended_enable < 2; k++) begin
      @(posedge mclk);
      if (single_ended_enable == 1) c++;
      if ((s == 0 ? dividedMasterClock : s == 1 ? serialClockTick : sampleTick) === 1'b1) single_ended_enable++;
    end
    if (single_ended_enable < 2) begin
      failures++;
      conclude();
    end
  endtask
  // Clock
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  // Main sequence
  initial begin
    reset_n = 0; clockEnable = 1; failures = 0; comparisons = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    for (i = 0; i < 8; i++) rdc(4 * i, 0);
    rdc(32'h20, 32'h08);
    rdc(32'h24, 0);
    check({hresp, hreadyout}, 2'b01);
    for (i = 0; i < 8; i++) wr(4 * i, pat[i]);
    for (i = 0; i < 8; i++) rdc(4 * i, pat[i]);
    check(cascadeCount, 5);
    check({serialLoopbackEnable, controlEchoEnable, testModeBit}, 3'b010);
    check({referencePinOutputEnable, highSupplyModeEnable, channelPowerOn}, 8'hff);
    check(channelGainCode, 18'h1e6ad);
    check({modulatorReset, singleEndedInput, polarityFlip}, {6'h05, 6'h05, 6'h0a});
    wr(8, 0);
    wr(32'h18, 8'h45);
    wr(32'h1c, 8'h0a);
    @(posedge mclk);
    check({referencePowerOn, referencePinOutputEnable, channelPowerOn}, 8'ha6);
    check({modulatorReset, singleEndedInput, polarityFlip}, {6'h05, 6'h00, 6'h00});
    for (i = 0; i < 4; i++) begin
      wr(0, i);
      @(posedge mclk);
      check({mixedMode, dataMode, programMode}, i[1] ? 3'b100 : i[0] ? 3'b010 : 3'b001);
    end
    clockEnable <= 1'b0;
    wr(32'h1c, 8'h3f);
    check(dividedMasterClock, 0);
    clockEnable <= 1'b1;
    rdc(32'h1c, 8'h0a);
    for (i = 0; i < 8; i++) begin
      wr(4, i << 4);
      period(0, n);
      period(0, n);
      check(n, i < 5 ? i + 1 : 1);
    end
    for (i = 0; i < 4; i++) begin
      wr(4, (i << 2) | i);
      period(1, n);
      period(1, n);
      check(n, 8 >> i);
      period(2, n);
      period(2, n);
      check(n, 2048 >> i);
    end
    wr(4, 8'h10);
    period(1, n);
    period(1, n);
    check(n, 16);
    wr(0, 8'h81);
    @(posedge mclk);
    check(softResetActive, 1);
    for (i = 0; i < 40 && softResetActive !== 1'b0; i++) @(posedge mclk);
    check(softResetActive, 0);
    if (softResetActive !== 1'b0) conclude();
    rdc(0, 0);
    rdc(4, 0);
    check(programMode, 1);
    period(0, n);
    period(0, n);
    check(n, 1);
    wr(8, 8'he1);
    rdc(8, 8'he1);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdc(8, 0);
    check({referencePowerOn, programMode}, 2'b01);
    conclude();
  end
endmodule // afe_control_register_bank_tb
bind afe_control_register_bank afe_control_register_bank_props #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire
